// [inc/sysref_align_pkg.sv]
// sysref_align_pkg: offsets, fields, reset values and timing counts of the
// sysref window and alignment calibration block.
// assumes an 8-bit register port with 12-bit addresses.
package sysref_align_pkg;
	// ==========================================================
	// register offsets
	localparam logic [11:0] CLK_CTRL_ADDR  = 12'h0029;
	localparam logic [11:0] MAP_LO_ADDR    = 12'h002C;
	localparam logic [11:0] MAP_MID_ADDR   = 12'h002D;
	localparam logic [11:0] MAP_HI_ADDR    = 12'h002E;
	localparam logic [11:0] CAL_EN_ADDR    = 12'h02B0;
	localparam logic [11:0] CAL_CFG_ADDR   = 12'h02B1;
	localparam logic [11:0] CAL_STAT_ADDR  = 12'h02B2;
	localparam logic [11:0] CAL_RES_ADDR   = 12'h02B3;
	localparam logic [11:0] DLY_FINE_ADDR  = 12'h02B5;
	localparam logic [11:0] DLY_COARSE_ADDR = 12'h02B6;
	localparam logic [11:0] TAD_CTRL_ADDR  = 12'h02B7;
	// ==========================================================
	// field positions
	localparam int SEL_LSB      = 0;  // clock control [3:0] capture phase select
	localparam int FINE_BIT     = 4;  // clock control [4] phase step fine
	localparam int DONE_BIT     = 0;  // status [0] done
	localparam int RES_INV_BIT  = 1;  // status [1] result invert
	localparam int INV_BIT      = 0;  // tad control [0] clock invert
	localparam int RAMP_EN_BIT  = 1;  // tad control [1] ramp enable
	localparam int RAMP_RATE_BIT = 2; // tad control [2] ramp rate fast
	// ==========================================================
	// reset values and counts
	localparam logic [7:0]  CAL_CFG_RST   = 8'h04;
	localparam logic [23:0] MAP_ALL_RISKY = 24'hFF_FFFF;
	localparam logic [1:0]  MAP_VALID_EDGES = 2'h3;
	localparam int          MAP_BITS      = 24;
	localparam int          SEL_BITS      = 4;
	localparam logic [7:0]  COARSE_MAX    = 8'hFF;
	localparam logic [7:0]  RAMP_SLOW     = 8'h01;
	localparam logic [7:0]  RAMP_FAST     = 8'h04;
	localparam logic [8:0]  RAMP_PERIOD   = 9'h180; // 384 device clocks per ramp step
	// ==========================================================
	// calibration engine states, gray along the sweep except CAL_NEXT back to CAL_SETTLE
	typedef enum logic [2:0] {
		CAL_IDLE   = 3'b000,
		CAL_SETTLE = 3'b001,
		CAL_SAMPLE = 3'b011,
		CAL_NEXT   = 3'b010,
		CAL_FINISH = 3'b110
	} cal_state_t;
endpackage

// [hdl/align_cal_engine.sv]
// align_cal_engine: sweeps clock invert and coarse delay until the internal
// clock falling edge meets the sysref rising edge, keeps the smaller coarse.
// assumes sr_edge and edge_lead are already synchronised to core_clk.
`timescale 1ns/10ps
`default_nettype none
module align_cal_engine
	import sysref_align_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset,
	// control
	input  wire logic       start,
	input  wire logic [3:0] settle_edges,
	input  wire logic       sr_edge,
	input  wire logic       edge_lead,
	// results
	output logic            sweep_inv,
	output logic [7:0]      sweep_coarse,
	output logic            done,
	output logic            res_inv,
	output logic [7:0]      res_coarse
);
	cal_state_t state_reg, state_next;
	logic [3:0] edge_cnt_reg;
	logic [7:0] found0_reg;
	logic       hit, last_step, pick_inv;

	// end of step decisions
	assign hit       = edge_lead;
	assign last_step = (sweep_coarse == COARSE_MAX);
	assign pick_inv  = (sweep_coarse < found0_reg); // inverted pass wins only if smaller

	// sweep sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CAL_IDLE:   if (start) state_next = CAL_SETTLE;
			CAL_SETTLE: if (sr_edge && edge_cnt_reg <= 4'h1) state_next = CAL_SAMPLE;
			CAL_SAMPLE: state_next = (hit || last_step) ? CAL_NEXT : CAL_SETTLE;
			CAL_NEXT:   state_next = sweep_inv ? CAL_FINISH : CAL_SETTLE;
			CAL_FINISH: state_next = CAL_FINISH;
			default:    state_next = CAL_IDLE;
		endcase
		if (!start) state_next = CAL_IDLE;
	end

	// sweep registers
	always_ff @(posedge core_clk) begin
		if (reset || !start) begin
			state_reg    <= CAL_IDLE;
			sweep_inv    <= 1'b0;
			sweep_coarse <= 8'h00;
			edge_cnt_reg <= 4'h0;
			found0_reg   <= COARSE_MAX;
			done         <= 1'b0;
		end else begin
			state_reg <= state_next;
			// first step waits one edge more unless settle_edges is 15: the applied delay and the lead
			// synchroniser take a few clocks before edge_lead shows the new code
			if (state_reg == CAL_IDLE)
				edge_cnt_reg <= (settle_edges == 4'hF) ? settle_edges : settle_edges + 4'h1;
			else if (state_reg == CAL_SAMPLE || state_reg == CAL_NEXT)
				edge_cnt_reg <= settle_edges;
			else if (sr_edge)
				edge_cnt_reg <= edge_cnt_reg - 4'h1;
			if (state_reg == CAL_SAMPLE && !hit && !last_step)
				sweep_coarse <= sweep_coarse + 8'h01;
			if (state_reg == CAL_NEXT && !sweep_inv) begin
				found0_reg   <= sweep_coarse;
				sweep_inv    <= 1'b1;
				sweep_coarse <= 8'h00;
			end
			if (state_reg == CAL_NEXT && sweep_inv)
				done <= 1'b1;
		end
	end

	// result kept until the next run
	always_ff @(posedge core_clk) begin
		if (reset) begin
			res_inv    <= 1'b0;
			res_coarse <= 8'h00;
		end else if (state_reg == CAL_NEXT && sweep_inv) begin
			res_inv    <= pick_inv;
			res_coarse <= pick_inv ? sweep_coarse : found0_reg;
		end
	end

	property p_done_smallest;
		@(posedge core_clk) disable iff (reset)
		$rose(done) |-> (res_inv ? res_coarse < found0_reg : res_coarse == found0_reg);
	endproperty
	a_done_smallest: assert property (p_done_smallest) else $error("result not smallest coarse");

	property p_done_after_inv;
		@(posedge core_clk) disable iff (reset)
		$rose(done) |-> $past(sweep_inv) && $past(state_reg) == CAL_NEXT;
	endproperty
	a_done_after_inv: assert property (p_done_after_inv) else $error("done before inverted pass");

	property p_step_on_miss;
		@(posedge core_clk) disable iff (reset)
		(start && state_reg == CAL_SAMPLE && !hit && !last_step) |=> sweep_coarse == $past(sweep_coarse) + 8'h01;
	endproperty
	a_step_on_miss: assert property (p_step_on_miss) else $error("coarse did not advance");

	c_cal_done: cover property (@(posedge core_clk) disable iff (reset) $rose(done));
	c_inv_wins: cover property (@(posedge core_clk) disable iff (reset) $rose(done) ##1 res_inv);
endmodule
`default_nettype wire

// [hdl/sysref_window_align.sv]
// sysref_window_align: sysref position map, capture phase select, delay
// ramp and automatic alignment calibration behind an 8-bit register port.
// assumes sysref, tap samples and edge_lead pins are asynchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none
module sysref_window_align
	import sysref_align_pkg::*;
(
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                reset,
	// register port
	input  wire logic [11:0]         reg_addr,
	input  wire logic                reg_wr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_rd,
	output logic [7:0]               reg_rdata,
	// sysref and delay line sampling, asynchronous
	input  wire logic                sysref,
	input  wire logic [MAP_BITS-1:0] tap_sample,
	input  wire logic                edge_lead,
	// analog delay controls
	output logic [SEL_BITS-1:0]      capture_phase_select,
	output logic                     phase_step_fine,
	output logic                     clock_invert_delay,
	output logic [7:0]               coarse_delay_code,
	output logic [7:0]               fine_delay_code
);
	// ==========================================================
	// synchronisers and sysref edge
	logic [MAP_BITS-1:0] tap_s1_reg, tap_s2_reg;
	logic [2:0]          sr_sync_reg;
	logic [1:0]          lead_sync_reg;
	logic                sr_edge;

	// two flops on every asynchronous input, third flop for the edge
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tap_s1_reg    <= '0;
			tap_s2_reg    <= '0;
			sr_sync_reg   <= 3'h0;
			lead_sync_reg <= 2'h0;
		end else begin
			tap_s1_reg    <= tap_sample;
			tap_s2_reg    <= tap_s1_reg;
			sr_sync_reg   <= {sr_sync_reg[1:0], sysref};
			lead_sync_reg <= {lead_sync_reg[0], edge_lead};
		end
	end
	assign sr_edge = sr_sync_reg[1] & ~sr_sync_reg[2];

	// ==========================================================
	// position detector
	logic [MAP_BITS-1:0] map_raw;
	logic [MAP_BITS-1:0] capture_phase_map_reg;
	logic [1:0]          edge_seen_reg;
	logic                map_valid;

	// a tap next to a transition is a setup or hold risk
	genvar gi;
	generate
		for (gi = 0; gi < MAP_BITS; gi++) begin : g_map
			if (gi == 0 || gi == MAP_BITS - 1) begin : g_end
				assign map_raw[gi] = 1'b1;
			end else begin : g_mid
				assign map_raw[gi] = (tap_s2_reg[gi] ^ tap_s2_reg[gi-1])
					| (tap_s2_reg[gi] ^ tap_s2_reg[gi+1]);
			end
		end
	endgenerate
	assign map_valid = (edge_seen_reg == MAP_VALID_EDGES);

	// map held all risky until three edges, then refreshed per edge
	always_ff @(posedge core_clk) begin
		if (reset) begin
			edge_seen_reg         <= 2'h0;
			capture_phase_map_reg <= MAP_ALL_RISKY;
		end else if (sr_edge) begin
			if (!map_valid)
				edge_seen_reg <= edge_seen_reg + 2'h1;
			if (edge_seen_reg >= MAP_VALID_EDGES - 2'h1)
				capture_phase_map_reg <= map_raw;
		end
	end

	// ==========================================================
	// software registers
	logic [7:0] clk_ctrl_reg, cal_cfg_reg, dly_fine_reg, dly_coarse_reg, tad_ctrl_reg;
	logic       cal_en_reg;
	logic       wr_clk, wr_en, wr_cfg, wr_fine, wr_coarse, wr_tad;

	assign wr_clk    = reg_wr && reg_addr == CLK_CTRL_ADDR;
	assign wr_en     = reg_wr && reg_addr == CAL_EN_ADDR;
	assign wr_cfg    = reg_wr && reg_addr == CAL_CFG_ADDR;
	assign wr_fine   = reg_wr && reg_addr == DLY_FINE_ADDR;
	assign wr_coarse = reg_wr && reg_addr == DLY_COARSE_ADDR;
	assign wr_tad    = reg_wr && reg_addr == TAD_CTRL_ADDR;

	// register writes
	always_ff @(posedge core_clk) begin
		if (reset) begin
			clk_ctrl_reg   <= 8'h00;
			cal_en_reg     <= 1'b0;
			cal_cfg_reg    <= CAL_CFG_RST;
			dly_fine_reg   <= 8'h00;
			dly_coarse_reg <= 8'h00;
			tad_ctrl_reg   <= 8'h00;
		end else begin
			if (wr_clk)    clk_ctrl_reg   <= reg_wdata;
			if (wr_en)     cal_en_reg     <= reg_wdata[0];
			if (wr_cfg)    cal_cfg_reg    <= reg_wdata;
			if (wr_fine)   dly_fine_reg   <= reg_wdata;
			if (wr_coarse) dly_coarse_reg <= reg_wdata;
			if (wr_tad)    tad_ctrl_reg   <= reg_wdata;
		end
	end

	// ==========================================================
	// calibration engine
	logic       cal_done, cal_res_inv, sweep_inv;
	logic [7:0] cal_res_coarse, sweep_coarse;
	logic [3:0] settle_edges;

	assign settle_edges = (cal_cfg_reg[3:0] == 4'h0) ? 4'h1 : cal_cfg_reg[3:0];

	align_cal_engine align_cal_engine_i (
		.core_clk     (core_clk),
		.reset        (reset),
		.start        (cal_en_reg),
		.settle_edges (settle_edges),
		.sr_edge      (sr_edge),
		.edge_lead    (lead_sync_reg[1]),
		.sweep_inv    (sweep_inv),
		.sweep_coarse (sweep_coarse),
		.done         (cal_done),
		.res_inv      (cal_res_inv),
		.res_coarse   (cal_res_coarse)
	);

	// ==========================================================
	// coarse delay ramp
	logic [8:0] ramp_div_reg;
	logic [7:0] ramp_coarse_reg, ramp_step, ramp_gap;
	logic       ramp_tick, ramp_up;

	assign ramp_tick = (ramp_div_reg == RAMP_PERIOD - 9'h001);
	assign ramp_up   = dly_coarse_reg > ramp_coarse_reg;
	assign ramp_gap  = ramp_up ? dly_coarse_reg - ramp_coarse_reg : ramp_coarse_reg - dly_coarse_reg;
	assign ramp_step = tad_ctrl_reg[RAMP_RATE_BIT] ? RAMP_FAST : RAMP_SLOW;

	// walk the applied coarse code toward the written one
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ramp_div_reg    <= 9'h000;
			ramp_coarse_reg <= 8'h00;
		end else if (!tad_ctrl_reg[RAMP_EN_BIT]) begin
			ramp_div_reg    <= 9'h000;
			ramp_coarse_reg <= dly_coarse_reg;
		end else begin
			ramp_div_reg <= (ramp_tick || wr_coarse) ? 9'h000 : ramp_div_reg + 9'h001;
			if (ramp_tick && ramp_gap != 8'h00) begin
				if (ramp_gap <= ramp_step)
					ramp_coarse_reg <= dly_coarse_reg;
				else if (ramp_up)
					ramp_coarse_reg <= ramp_coarse_reg + ramp_step;
				else
					ramp_coarse_reg <= ramp_coarse_reg - ramp_step;
			end
		end
	end

	// ==========================================================
	// delay selection and outputs
	logic       inv_sel;
	logic [7:0] coarse_sel;

	// sweep while running, result once done, manual when disabled
	assign inv_sel    = !cal_en_reg ? tad_ctrl_reg[INV_BIT] : cal_done ? cal_res_inv : sweep_inv;
	assign coarse_sel = !cal_en_reg ? ramp_coarse_reg : cal_done ? cal_res_coarse : sweep_coarse;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			capture_phase_select <= '0;
			phase_step_fine      <= 1'b0;
			clock_invert_delay   <= 1'b0;
			coarse_delay_code    <= 8'h00;
			fine_delay_code      <= 8'h00;
		end else begin
			capture_phase_select <= clk_ctrl_reg[SEL_LSB +: SEL_BITS];
			phase_step_fine      <= clk_ctrl_reg[FINE_BIT];
			clock_invert_delay   <= inv_sel;
			coarse_delay_code    <= coarse_sel;
			fine_delay_code      <= dly_fine_reg;
		end
	end

	// ==========================================================
	// register read back, one cycle after the strobe
	logic [7:0] rd_mux;

	always_comb begin
		case (reg_addr)
			CLK_CTRL_ADDR:   rd_mux = clk_ctrl_reg;
			MAP_LO_ADDR:     rd_mux = capture_phase_map_reg[7:0];
			MAP_MID_ADDR:    rd_mux = capture_phase_map_reg[15:8];
			MAP_HI_ADDR:     rd_mux = capture_phase_map_reg[23:16];
			CAL_EN_ADDR:     rd_mux = {7'h00, cal_en_reg};
			CAL_CFG_ADDR:    rd_mux = cal_cfg_reg;
			CAL_STAT_ADDR:   rd_mux = {6'h00, cal_res_inv, cal_done};
			CAL_RES_ADDR:    rd_mux = cal_res_coarse;
			DLY_FINE_ADDR:   rd_mux = dly_fine_reg;
			DLY_COARSE_ADDR: rd_mux = dly_coarse_reg;
			TAD_CTRL_ADDR:   rd_mux = tad_ctrl_reg;
			default:         rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_mux;
	end

	// ==========================================================
	// checks
	property p_map_risky_early;
		@(posedge core_clk) disable iff (reset)
		(edge_seen_reg < MAP_VALID_EDGES - 2'h1) |-> capture_phase_map_reg == MAP_ALL_RISKY;
	endproperty
	a_map_risky_early: assert property (p_map_risky_early) else $error("map changed before three edges");

	property p_map_ends;
		@(posedge core_clk) disable iff (reset)
		capture_phase_map_reg[0] && capture_phase_map_reg[MAP_BITS-1];
	endproperty
	a_map_ends: assert property (p_map_ends) else $error("map end bits not set");

	property p_map_refresh;
		@(posedge core_clk) disable iff (reset)
		(sr_edge && map_valid) |=> capture_phase_map_reg == $past(map_raw);
	endproperty
	a_map_refresh: assert property (p_map_refresh) else $error("map not refreshed on edge");

	property p_cal_hold;
		@(posedge core_clk) disable iff (reset)
		(cal_en_reg && cal_done) ##1 (cal_en_reg && cal_done)
			|-> coarse_delay_code == cal_res_coarse && clock_invert_delay == cal_res_inv;
	endproperty
	a_cal_hold: assert property (p_cal_hold) else $error("calibrated delay not applied");

	property p_ramp_rate;
		@(posedge core_clk) disable iff (reset)
		(tad_ctrl_reg[RAMP_EN_BIT] && !ramp_tick && !cal_en_reg) ##1 tad_ctrl_reg[RAMP_EN_BIT]
			|-> ramp_coarse_reg == $past(ramp_coarse_reg);
	endproperty
	a_ramp_rate: assert property (p_ramp_rate) else $error("ramp moved off its tick");

	property p_read_map;
		@(posedge core_clk) disable iff (reset)
		(reg_rd && reg_addr == MAP_HI_ADDR) |=> reg_rdata == $past(capture_phase_map_reg[23:16]);
	endproperty
	a_read_map: assert property (p_read_map) else $error("map high byte misread");

	c_map_valid: cover property (@(posedge core_clk) disable iff (reset) $rose(map_valid));
	c_ramp_fast: cover property (@(posedge core_clk) disable iff (reset)
		ramp_tick && tad_ctrl_reg[RAMP_RATE_BIT] && ramp_gap > RAMP_FAST);
	c_sel_write: cover property (@(posedge core_clk) disable iff (reset) wr_clk ##1 capture_phase_select != '0);
endmodule
`default_nettype wire

// [bench/sysref_source_model.sv]
// sysref_source_model: external clock source with a periodic sysref, tap
// samples of sysref and the internal phase detector answer.
// assumes core_clk comes from the bench; targets set the aligning coarse code.
`timescale 1ns/10ps
`default_nettype none
module sysref_source_model #(
	parameter int SR_PERIOD = 16
) (
	// clock and control
	input  wire logic        core_clk,
	input  wire logic        run,
	input  wire logic [23:0] tap_pattern,
	input  wire logic [7:0]  target_plain,
	input  wire logic [7:0]  target_inv,
	// delay applied by the device
	input  wire logic        clock_invert_delay,
	input  wire logic [7:0]  coarse_delay_code,
	// pins into the device
	output logic             sysref,
	output logic [23:0]      tap_sample,
	output logic             edge_lead
);
	// ==========================================================
	// sysref generation
	int phase = 0;

	initial sysref = 1'b0;
	// free running, never a single pulse while run is high
	always @(negedge core_clk) begin
		phase <= (phase + 1) % SR_PERIOD;
		sysref <= run && (phase < SR_PERIOD / 2);
	end

	// ==========================================================
	// sampled window and phase detector
	assign tap_sample = tap_pattern;
	// clock fall reaches the sysref rise once coarse meets the target
	assign edge_lead = clock_invert_delay ? (coarse_delay_code >= target_inv) :
		(coarse_delay_code >= target_plain);
endmodule
`default_nettype wire

// [bench/sysref_window_align_tb_top.sv]
// sysref_window_align_tb_top: register level tests of map, select, delay,
// ramp and calibration through the 8-bit register port.
// assumes the package and the source model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module sysref_window_align_tb_top;
	import sysref_align_pkg::*;
	// ==========================================================
	// signals
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic [11:0] reg_addr = 12'h000;
	logic        reg_wr = 1'b0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        sysref;
	logic [23:0] tap_sample;
	logic        edge_lead;
	logic [3:0]  sel;
	logic        fine;
	logic        inv;
	logic [7:0]  coarse;
	logic [7:0]  fdel;
	logic        run = 1'b0;
	logic [23:0] tap_pattern = 24'h00_0000;
	logic [7:0]  t_plain = 8'h00;
	logic [7:0]  t_inv = 8'h00;
	logic [7:0]  rd_val;
	int          err_total = 0;
	int          n_compared = 0;
	int          guard;
	logic [7:0]  cases [3][3] = '{'{8'h09, 8'h05, 8'h01}, '{8'h03, 8'h07, 8'h00}, '{8'h04, 8'h04, 8'h00}};

	always #4 core_clk = ~core_clk;

	sysref_window_align sysref_window_align_i (
		.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sysref(sysref),
		.tap_sample(tap_sample), .edge_lead(edge_lead), .capture_phase_select(sel),
		.phase_step_fine(fine), .clock_invert_delay(inv), .coarse_delay_code(coarse),
		.fine_delay_code(fdel));

	sysref_source_model sysref_source_model_i (
		.core_clk(core_clk), .run(run), .tap_pattern(tap_pattern), .target_plain(t_plain),
		.target_inv(t_inv), .clock_invert_delay(inv), .coarse_delay_code(coarse),
		.sysref(sysref), .tap_sample(tap_sample), .edge_lead(edge_lead));

	// ==========================================================
	// tasks
	task automatic end_sim();
		if (err_total == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask

	// strobe one cycle, sample two falling edges later while data holds
	task automatic reg_read(input logic [11:0] a, output logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask

	task automatic chk_reg(input logic [11:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		reg_read(a, d);
		cmp8(d, exp, what);
	endtask

	// three bytes, lowest address holds the smallest delays
	task automatic chk_map(input logic [23:0] exp);
		chk_reg(MAP_LO_ADDR, exp[7:0], "map low");
		chk_reg(MAP_MID_ADDR, exp[15:8], "map mid");
		chk_reg(MAP_HI_ADDR, exp[23:16], "map high");
	endtask

	task automatic wait_rises(input int n, input int gap);
		int seen;
		int cnt;
		logic last;
		seen = 0;
		cnt = 0;
		last = sysref;
		while (seen < n) begin
			@(posedge core_clk);
			seen += (sysref && !last) ? 1 : 0;
			last = sysref;
			cnt++;
			if (cnt > 1000) begin
				err_total++;
				$display("CHECK FAILED at %0t: sysref edge wait ran out", $time);
				end_sim();
			end
		end
		repeat (gap) @(negedge core_clk);
	endtask

	// expected risk map from tap transitions, edge bits always risky
	function automatic logic [23:0] map_of(input logic [23:0] t);
		logic [23:0] m;
		m = 24'hFF_FFFF;
		for (int i = 1; i < 23; i++) begin
			m[i] = (t[i] != t[i-1]) || (t[i] != t[i+1]);
		end
		return m;
	endfunction

	// ==========================================================
	// main sequence
	initial begin
		repeat (3) @(negedge core_clk);
		reset = 1'b0;
		chk_map(MAP_ALL_RISKY);
		chk_reg(CAL_CFG_ADDR, CAL_CFG_RST, "cal config reset");
		chk_reg(12'h0FF, 8'h00, "unmapped read");
		reg_write(MAP_LO_ADDR, 8'h00);
		chk_reg(MAP_LO_ADDR, 8'hFF, "map is read only");
		// position detector, valid only from the third rise
		tap_pattern = 24'h0F_00F0;
		run = 1'b1;
		wait_rises(2, 4);
		chk_map(MAP_ALL_RISKY);
		wait_rises(1, 6);
		chk_map(map_of(24'h0F_00F0));
		tap_pattern = 24'h7C_3C3E;
		wait_rises(1, 6);
		chk_map(map_of(24'h7C_3C3E));
		// phase select and step size
		reg_write(CLK_CTRL_ADDR, 8'h1F);
		repeat (2) @(negedge core_clk);
		cmp8({4'h0, sel}, 8'h0F, "select 15");
		cmp8({7'h00, fine}, 8'h01, "fine steps");
		reg_write(CLK_CTRL_ADDR, 8'h00);
		repeat (2) @(negedge core_clk);
		cmp8({3'h0, fine, sel}, 8'h00, "coarse steps, select 0");
		// manual delay written directly, ramp off
		reg_write(TAD_CTRL_ADDR, 8'h01);
		reg_write(DLY_FINE_ADDR, 8'h5A);
		reg_write(DLY_COARSE_ADDR, 8'h20);
		repeat (2) @(negedge core_clk);
		cmp8({inv, fdel[6:0]}, 8'hDA, "invert and fine");
		cmp8(coarse, 8'h20, "coarse direct");
		// slow ramp, then fast ramp, one step per 384 clocks
		reg_write(TAD_CTRL_ADDR, 8'h02);
		reg_write(DLY_COARSE_ADDR, 8'h22);
		repeat (370) @(negedge core_clk);
		cmp8(coarse, 8'h20, "slow before step");
		repeat (20) @(negedge core_clk);
		cmp8(coarse, 8'h21, "slow first step");
		repeat (784) @(negedge core_clk);
		cmp8(coarse, 8'h22, "slow stops at target");
		reg_write(TAD_CTRL_ADDR, 8'h06);
		reg_write(DLY_COARSE_ADDR, 8'h2A);
		repeat (370) @(negedge core_clk);
		cmp8(coarse, 8'h22, "fast before step");
		repeat (20) @(negedge core_clk);
		cmp8(coarse, 8'h26, "fast first step");
		repeat (400) @(negedge core_clk);
		cmp8(coarse, 8'h2A, "fast reaches target");
		reg_write(TAD_CTRL_ADDR, 8'h00);
		// calibration: converter calibration idle, select held at 0
		for (int c = 0; c < 3; c++) begin
			t_plain = cases[c][0];
			t_inv = cases[c][1];
			reg_write(CAL_EN_ADDR, 8'h00);
			// done drops with the enable, the invert result of the last run stays
			chk_reg(CAL_STAT_ADDR, {6'h00, (c > 0) && cases[(c + 2) % 3][2][0], 1'b0}, "done cleared");
			reg_write(CAL_CFG_ADDR, 8'h01);
			reg_write(CAL_EN_ADDR, 8'h01);
			guard = 0;
			rd_val = 8'h00;
			while (rd_val[DONE_BIT] !== 1'b1 && guard < 400) begin
				reg_read(CAL_STAT_ADDR, rd_val);
				guard++;
			end
			if (rd_val[DONE_BIT] !== 1'b1) begin
				err_total++;
				$display("CHECK FAILED at %0t: calibration done wait ran out", $time);
				end_sim();
			end
			cmp8(rd_val, {6'h00, cases[c][2][0], 1'b1}, "done and invert");
			chk_reg(CAL_RES_ADDR, cases[c][2][0] ? t_inv : t_plain, "result coarse");
			repeat (50) @(negedge core_clk);
			cmp8({inv, coarse[6:0]}, {cases[c][2][0], cases[c][2][0] ? t_inv[6:0] : t_plain[6:0]},
				"calibrated delay in use");
		end
		reg_write(CAL_EN_ADDR, 8'h00);
		repeat (2) @(negedge core_clk);
		cmp8({inv, coarse[6:0]}, 8'h2A, "manual delay back");
		chk_reg(CAL_RES_ADDR, 8'h04, "result kept");
		end_sim();
	end
endmodule
`default_nettype wire
